// File: mmd_pkg.sv
// memory map decoder: address map, timing counts, request/route types
// assumes a 24-bit byte address from the cpu and a 125 MHz core clock
`default_nettype none
package mmd_pkg;
    localparam int ADDR_W = 24;
    localparam int NUM_WIN = 4;
    // fixed on-chip ranges, byte addresses
    localparam logic [23:0] EXTENSION_RAM_LO = 24'h00E000;
    localparam logic [23:0] EXTENSION_RAM_HI = 24'h00E7FF;
    localparam logic [23:0] CAN_LO = 24'h00EF00;
    localparam logic [23:0] CAN_HI = 24'h00EFFF;
    localparam logic [23:0] EXTENDED_SPECIAL_FUNCTION_AREA_LO = 24'h00F000;
    localparam logic [23:0] EXTENDED_SPECIAL_FUNCTION_AREA_HI = 24'h00F1FF;
    localparam logic [23:0] INTERNAL_DUAL_PORT_RAM_LO = 24'h00F600;
    localparam logic [23:0] INTERNAL_DUAL_PORT_RAM_HI = 24'h00FDFF;
    localparam logic [23:0] SFR_LO = 24'h00FE00;
    localparam logic [23:0] SFR_HI = 24'h00FFFF;
    // bit-addressable slices of on-chip memory
    localparam logic [23:0] INTERNAL_DUAL_PORT_RAM_BIT_LO = 24'h00FD00;
    localparam logic [23:0] EXTENDED_SPECIAL_FUNCTION_AREA_BIT_LO = 24'h00F100;
    localparam logic [23:0] SFR_BIT_LO = 24'h00FF00;
    // system_config_reg field
    localparam int SYSCFG_PBE_BIT = 2;
    // external segment lines left when the can module is in use
    localparam int CAN_SEG_LINES = 4;
    localparam int SEG_MSB_CAN = 15 + CAN_SEG_LINES;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int EXTENSION_RAM_ACCESS_NS = 80;
    localparam int CAN_ACCESS_NS = 160;
    localparam int EXTENSION_RAM_CYCLES =
        (EXTENSION_RAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAN_CYCLES =
        (CAN_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ONCHIP_CYCLES = 1;
    // one-hot select positions
    localparam int SEL_INTERNAL_DUAL_PORT_RAM = 0;
    localparam int SEL_SFR = 1;
    localparam int SEL_EXTENDED_SPECIAL_FUNCTION_AREA = 2;
    localparam int SEL_EXTENSION_RAM = 3;
    localparam int SEL_CAN = 4;
    localparam int SEL_EXT = 5;
    localparam int SEL_W = 6;

    typedef enum logic [2:0] {
        MMD_TGT_INTERNAL_DUAL_PORT_RAM, MMD_TGT_SFR, MMD_TGT_EXTENDED_SPECIAL_FUNCTION_AREA,
        MMD_TGT_EXTENSION_RAM, MMD_TGT_CAN, MMD_TGT_EXT
    } mmd_target_type;

    typedef enum logic [1:0] {
        MMD_USE_DATA, MMD_USE_CODE, MMD_USE_STACK, MMD_USE_GPR
    } mmd_use_type;

    typedef enum logic [1:0] {
        MMD_FLT_NONE, MMD_FLT_BIT, MMD_FLT_PLACE
    } mmd_fault_type;

    typedef struct packed {
        logic [23:0] addr;
        logic is_word;
        logic is_write;
        logic bit_op;
        mmd_use_type use_kind;
        logic [3:0] gpr_num;
    } mmd_req_type;

    typedef struct packed {
        logic enable;
        logic [11:0] base;
        logic [11:0] mask;
    } mmd_window_type;

    typedef struct packed {
        mmd_target_type target;
        logic [23:0] addr;
        logic is_word;
        logic is_write;
        logic bit_op;
        logic [2:0] window;
    } mmd_route_type;

    function automatic logic mmd_in_range(input logic [23:0] a,
                                          input logic [23:0] lo,
                                          input logic [23:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction
endpackage
`default_nettype wire

// File: mmd_window_sel.sv
// external bus window matcher with fixed priority
// assumes window configs are stable registers in the bus controller
`timescale 1ns/1ps
`default_nettype none
module mmd_window_sel (
    // address and window setup
    input wire logic [23:0] addr_in,
    input wire mmd_pkg::mmd_window_type [mmd_pkg::NUM_WIN-1:0] windows_in,
    // chosen window, 0 is the default configuration
    output wire logic [2:0] window_out
);
    import mmd_pkg::*;
    logic [NUM_WIN-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NUM_WIN; g++) begin : g_win
            assign hit[g] = windows_in[g].enable &&
                ((addr_in[23:12] & windows_in[g].mask) == windows_in[g].base);
        end
    endgenerate
    // later windows override earlier ones
    assign window_out = hit[3] ? 3'h4 : // [RULE15]
                        hit[2] ? 3'h3 :
                        hit[1] ? 3'h2 :
                        hit[0] ? 3'h1 : 3'h0;
endmodule
`default_nettype wire

// File: mmd_decoder.sv
// memory map decoder: routes cpu byte/word accesses to one target
// and paces fixed-latency targets; external targets answer on ext_done_in
// Functional notes
// RULE1 - code, data, registers and i/o share one 16M byte space decoded alike.
// RULE2 - every location takes byte and word accesses, size given by the cpu.
// RULE3 - only chosen on-chip slices allow single-bit access.
// RULE4 - the 2K internal ram serves data, stack, register banks and code.
// RULE5 - a bank gives 16 word registers, the low eight also as 16 bytes.
// RULE6 - with the peripheral-bus enable set, E000h-E7FFh is extension ram; the code also requires ext_ram_enable_in set.
// RULE7 - extension ram cycles are 16-bit, no waits, 80ns long.
// RULE8 - extension ram allows byte/word but no bit access, stack or bank.
// RULE9 - with extension ram off, its range goes to the external bus.
// RULE10 - two 512-byte word-wide special function areas are reserved.
// RULE11 - EF00h-EFFFh reaches the can module only with the enable bit set.
// RULE12 - can accesses are 16-bit demultiplexed, two waits, 160ns long.
// RULE13 - with can in use only 4 segment lines drive out, 1M per select.
// RULE14 - unclaimed addresses go to the external bus, up to 16M bytes.
// RULE15 - window 4 beats 3, 2 beats 1, unmatched uses the default.
// RULE16 - each access hits one target, enabled on-chip ranges first.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // configuration
    input wire logic [15:0] system_config_reg_in,
    input wire logic ext_ram_enable_in,
    input wire mmd_pkg::mmd_window_type [mmd_pkg::NUM_WIN-1:0] windows_in,
    input wire logic [23:0] context_ptr_in,
    // cpu request
    input wire logic req_valid_in,
    input wire mmd_pkg::mmd_req_type req_in,
    output logic req_ready_out,
    output logic done_out,
    output mmd_pkg::mmd_fault_type fault_out,
    // target side
    output mmd_pkg::mmd_route_type route_out,
    output logic [mmd_pkg::SEL_W-1:0] target_sel_out,
    input wire logic ext_done_in
);
    import mmd_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_FIXED, ST_EXT} mmd_state_type;

    mmd_state_type state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    mmd_fault_type fault_q, fault_d;
    mmd_route_type route_q, route_d;
    logic [SEL_W-1:0] sel_q, sel_d;

    wire logic periph_bus_enable = system_config_reg_in[SYSCFG_PBE_BIT];
    wire logic extension_ram_on = periph_bus_enable && ext_ram_enable_in;
    wire logic can_on = periph_bus_enable;
    wire logic take = req_valid_in && ready_q;
    wire logic use_gpr = (req_in.use_kind == MMD_USE_GPR);
    wire logic use_stack = (req_in.use_kind == MMD_USE_STACK);

    // byte regs n map to byte n of the bank, so only words 0..7 are split
    wire logic [23:0] gpr_word_addr =
        context_ptr_in + {19'h00000, req_in.gpr_num, 1'b0}; // [RULE5]
    wire logic [23:0] gpr_byte_addr =
        context_ptr_in + {20'h00000, req_in.gpr_num}; // [RULE5]
    wire logic [23:0] eff_addr = !use_gpr ? req_in.addr :
        (req_in.is_word ? gpr_word_addr : gpr_byte_addr);

    // use_kind enters target choice only via the gpr address: code and data decode alike
    wire logic hit_internal_dual_port_ram = mmd_in_range(eff_addr, INTERNAL_DUAL_PORT_RAM_LO, INTERNAL_DUAL_PORT_RAM_HI); // [RULE1]
    wire logic hit_sfr = mmd_in_range(eff_addr, SFR_LO, SFR_HI); // [RULE10]
    wire logic hit_extended_special_function_area = mmd_in_range(eff_addr, EXTENDED_SPECIAL_FUNCTION_AREA_LO, EXTENDED_SPECIAL_FUNCTION_AREA_HI); // [RULE10]
    wire logic hit_extension_ram = mmd_in_range(eff_addr, EXTENSION_RAM_LO, EXTENSION_RAM_HI);
    wire logic hit_can = mmd_in_range(eff_addr, CAN_LO, CAN_HI);
    wire logic bit_ok = mmd_in_range(eff_addr, INTERNAL_DUAL_PORT_RAM_BIT_LO, INTERNAL_DUAL_PORT_RAM_HI) ||
                        mmd_in_range(eff_addr, EXTENDED_SPECIAL_FUNCTION_AREA_BIT_LO, EXTENDED_SPECIAL_FUNCTION_AREA_HI) ||
                        mmd_in_range(eff_addr, SFR_BIT_LO, SFR_HI); // [RULE3]

    wire logic [2:0] win_idx;
    mmd_window_sel u_win (
        .addr_in(eff_addr),
        .windows_in(windows_in),
        .window_out(win_idx)
    );

    // on-chip first, disabled on-chip ranges fall through to external
    wire mmd_target_type tgt =
        hit_internal_dual_port_ram ? MMD_TGT_INTERNAL_DUAL_PORT_RAM : // [RULE4] [RULE16]
        hit_sfr ? MMD_TGT_SFR :
        hit_extended_special_function_area ? MMD_TGT_EXTENDED_SPECIAL_FUNCTION_AREA :
        (hit_extension_ram && extension_ram_on) ? MMD_TGT_EXTENSION_RAM : // [RULE6] [RULE9]
        (hit_can && can_on) ? MMD_TGT_CAN : // [RULE11]
        MMD_TGT_EXT; // [RULE14]

    // stack and banks only live in internal ram, never in extension ram
    wire mmd_fault_type flt =
        (req_in.bit_op && !bit_ok) ? MMD_FLT_BIT : // [RULE3] [RULE8]
        ((use_stack || use_gpr) && tgt != MMD_TGT_INTERNAL_DUAL_PORT_RAM) ? // [RULE8]
        MMD_FLT_PLACE : MMD_FLT_NONE;

    // upper segment lines dropped: 1M reach while can is in use
    wire logic [23:0] ext_addr = can_on ?
        {4'h0, eff_addr[SEG_MSB_CAN:0]} : eff_addr; // [RULE13]

    wire logic [4:0] fixed_len =
        (tgt == MMD_TGT_EXTENSION_RAM) ? 5'(EXTENSION_RAM_CYCLES - 1) : // [RULE7]
        (tgt == MMD_TGT_CAN) ? 5'(CAN_CYCLES - 1) : // [RULE12]
        5'(ONCHIP_CYCLES - 1);

    wire logic [SEL_W-1:0] tgt_onehot = 6'h01 << tgt; // [RULE16]

    wire mmd_route_type new_route = '{
        target: tgt,
        addr: (tgt == MMD_TGT_EXT) ? ext_addr : eff_addr,
        is_word: req_in.is_word, // [RULE2]
        is_write: req_in.is_write,
        bit_op: req_in.bit_op,
        window: (tgt == MMD_TGT_EXT) ? win_idx : 3'h0 // [RULE15]
    };

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ready_d = ready_q;
        done_d = 1'b0;
        fault_d = fault_q;
        route_d = route_q;
        sel_d = sel_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    route_d = new_route;
                    if (flt != MMD_FLT_NONE) begin
                        done_d = 1'b1;
                        fault_d = flt;
                    end else begin
                        sel_d = tgt_onehot;
                        ready_d = 1'b0;
                        cnt_d = fixed_len;
                        state_d = (tgt == MMD_TGT_EXT) ? ST_EXT : ST_FIXED;
                    end
                end
            end
            ST_FIXED: begin
                if (cnt_q == 5'h00) begin
                    sel_d = '0;
                    done_d = 1'b1;
                    fault_d = MMD_FLT_NONE;
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            ST_EXT: begin
                if (ext_done_in) begin
                    sel_d = '0;
                    done_d = 1'b1;
                    fault_d = MMD_FLT_NONE;
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                sel_d = '0;
                ready_d = 1'b1;
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            fault_q <= MMD_FLT_NONE;
            route_q <= '0;
            sel_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            done_q <= done_d;
            fault_q <= fault_d;
            route_q <= route_d;
            sel_q <= sel_d;
        end
    end

    assign req_ready_out = ready_q;
    assign done_out = done_q;
    assign fault_out = fault_q;
    assign route_out = route_q;
    assign target_sel_out = sel_q;

    chk_extension_ram_timing: assert property ( // [RULE7]
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(sel_q[SEL_EXTENSION_RAM]) |-> sel_q[SEL_EXTENSION_RAM] [*8] ##1
        sel_q[SEL_EXTENSION_RAM] [*2] ##1 (!sel_q[SEL_EXTENSION_RAM] && done_q))
        else $error("extension ram access not ten cycles");

    chk_can_timing: assert property ( // [RULE12]
        @(posedge sys_clk_in) disable iff (reset_in)
        $rose(sel_q[SEL_CAN]) |-> ##20 done_q && !sel_q[SEL_CAN])
        else $error("can access not twenty cycles");

    chk_one_target: assert property ( // [RULE16]
        @(posedge sys_clk_in) disable iff (reset_in)
        $onehot0(sel_q) && (|sel_q == !ready_q))
        else $error("select not one-hot or ready mismatch");

    chk_extension_ram_off_ext: assert property ( // [RULE9]
        @(posedge sys_clk_in) disable iff (reset_in)
        take && hit_extension_ram && !extension_ram_on && flt == MMD_FLT_NONE |=>
        sel_q[SEL_EXT] && route_q.target == MMD_TGT_EXT)
        else $error("disabled extension ram range not external");

    chk_can_gate: assert property ( // [RULE11]
        @(posedge sys_clk_in) disable iff (reset_in)
        take && hit_can && flt == MMD_FLT_NONE |=>
        sel_q[SEL_CAN] == $past(can_on))
        else $error("can window gating wrong");

    chk_bit_refused: assert property ( // [RULE3]
        @(posedge sys_clk_in) disable iff (reset_in)
        take && req_in.bit_op && (hit_extension_ram || hit_can) |=>
        done_q && fault_q == MMD_FLT_BIT && sel_q == '0)
        else $error("bit access outside bit slices accepted");

    chk_stack_place: assert property ( // [RULE8]
        @(posedge sys_clk_in) disable iff (reset_in)
        take && use_stack && !hit_internal_dual_port_ram && !req_in.bit_op |=>
        done_q && fault_q == MMD_FLT_PLACE)
        else $error("stack outside internal ram accepted");

    chk_seg_limit: assert property ( // [RULE13]
        @(posedge sys_clk_in) disable iff (reset_in)
        take && can_on && tgt == MMD_TGT_EXT |=> route_q.addr[23:20] == 4'h0)
        else $error("upper segment lines driven with can in use");

    chk_gpr_word: assert property ( // [RULE5]
        @(posedge sys_clk_in) disable iff (reset_in)
        take && use_gpr && req_in.is_word && hit_internal_dual_port_ram |=>
        route_q.addr == $past(context_ptr_in) + {19'h0, $past(req_in.gpr_num),
        1'b0})
        else $error("word register address wrong");

    chk_size_kept: assert property ( // [RULE2]
        @(posedge sys_clk_in) disable iff (reset_in)
        take |=> route_q.is_word == $past(req_in.is_word))
        else $error("access size lost");

    chk_window_pick: assert property ( // [RULE15]
        @(posedge sys_clk_in) disable iff (reset_in)
        take && tgt == MMD_TGT_EXT && flt == MMD_FLT_NONE |=>
        route_q.window == $past(win_idx) && state_q == ST_EXT)
        else $error("external window not carried");
endmodule
`default_nettype wire

// File: mmd_ext_model.sv
// stand-in for the external bus controller: ends each external access
// assumes the decoder clock; answer delay is set by the bench
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_model (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // decoder side
    input wire logic ext_sel_in,
    input wire logic [3:0] delay_in,
    output logic ext_done_out
);
    import mmd_pkg::*;
    logic [3:0] wait_q;
    // one pulse per access, delay_in+1 cycles after the select is first seen high, no early answer
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wait_q <= 4'h0;
            ext_done_out <= 1'b0;
        end else begin
            ext_done_out <= 1'b0;
            if (ext_sel_in && !ext_done_out) begin
                if (wait_q == delay_in) begin
                    ext_done_out <= 1'b1;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the memory map decoder
// assumes the external bus controller stand-in answers external accesses
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mmd_pkg::*;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [15:0] sys_cfg = 16'h0000;
    logic extension_ram_en = 1'b0;
    mmd_window_type [NUM_WIN-1:0] windows = '0;
    logic [23:0] cp = 24'h00FC00;
    logic req_valid_in = 1'b0;
    mmd_req_type req_in = '0;
    logic req_ready_out, done_out, ext_done;
    mmd_fault_type fault_out;
    mmd_route_type route_out;
    logic [SEL_W-1:0] target_sel_out;
    logic [3:0] ext_delay = 4'h0;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;

    mmd_decoder uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .system_config_reg_in(sys_cfg), .ext_ram_enable_in(extension_ram_en),
        .windows_in(windows), .context_ptr_in(cp),
        .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .done_out(done_out),
        .fault_out(fault_out), .route_out(route_out),
        .target_sel_out(target_sel_out), .ext_done_in(ext_done));
    mmd_ext_model ext_bus (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .ext_sel_in(target_sel_out[SEL_EXT]), .delay_in(ext_delay),
        .ext_done_out(ext_done));

    initial forever #4 sys_clk_in = ~sys_clk_in;

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ceiling well above the roughly 120 cycles the scenarios need
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    function automatic mmd_req_type mk(input logic [23:0] a, input logic w,
            input logic b, input mmd_use_type u, input logic [3:0] g);
        return '{addr: a, is_word: w, is_write: ~w, bit_op: b,
                 use_kind: u, gpr_num: g};
    endfunction

    // select line expected for each target kind
    function automatic logic [SEL_W-1:0] exp_sel(input mmd_target_type t);
        logic [SEL_W-1:0] s;
        s = '0;
        case (t)
            MMD_TGT_INTERNAL_DUAL_PORT_RAM: s[SEL_INTERNAL_DUAL_PORT_RAM] = 1'b1;
            MMD_TGT_SFR: s[SEL_SFR] = 1'b1;
            MMD_TGT_EXTENDED_SPECIAL_FUNCTION_AREA: s[SEL_EXTENDED_SPECIAL_FUNCTION_AREA] = 1'b1;
            MMD_TGT_EXTENSION_RAM: s[SEL_EXTENSION_RAM] = 1'b1;
            MMD_TGT_CAN: s[SEL_CAN] = 1'b1;
            default: s[SEL_EXT] = 1'b1;
        endcase
        return s;
    endfunction

    // one access; sel_n < 0 skips the length check, win < 0 the window
    task automatic access(input mmd_req_type r, input mmd_target_type tgt,
            input int sel_n, input mmd_fault_type flt, input int win);
        int n;
        int k;
        logic [SEL_W-1:0] sel_seen;
        logic [SEL_W-1:0] sel_exp;
        n = 0;
        k = 0;
        sel_seen = '0;
        sel_exp = (flt == MMD_FLT_NONE) ? exp_sel(tgt) : '0;
        @(posedge sys_clk_in);
        req_in <= r;
        req_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        req_valid_in <= 1'b0;
        #1;
        while (done_out !== 1'b1 && k < 200) begin
            if (target_sel_out !== '0) n++;
            sel_seen = sel_seen | target_sel_out;
            @(posedge sys_clk_in);
            #1;
            k++;
        end
        check("done", done_out, 1);
        check("ready", req_ready_out, 1);
        check("fault", fault_out, flt);
        check("sel bit", sel_seen, sel_exp);
        check("write", route_out.is_write, r.is_write);
        check("bit op", route_out.bit_op, r.bit_op);
        if (sel_n >= 0) check("sel cycles", n, sel_n);
        if (flt == MMD_FLT_NONE)
            check("target", route_out.target, tgt);
        if (win >= 0) check("window", route_out.window, win);
    endtask

    task automatic t_reset();
        check("reset ready", req_ready_out, 1);
        check("reset sel", target_sel_out, 0);
        check("reset done", done_out, 0);
        check("reset fault", fault_out, MMD_FLT_NONE);
        check("reset route", route_out.addr, 0);
    endtask

    task automatic t_onchip();
        access(mk(24'h00F600, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_INTERNAL_DUAL_PORT_RAM, ONCHIP_CYCLES, MMD_FLT_NONE, -1);
        check("is_word", route_out.is_word, 1);
        access(mk(24'h00FDFF, 1'b0, 1'b0, MMD_USE_CODE, 4'h0),
               MMD_TGT_INTERNAL_DUAL_PORT_RAM, ONCHIP_CYCLES, MMD_FLT_NONE, -1);
        check("is_byte", route_out.is_word, 0);
        access(mk(24'h00FE00, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_SFR, ONCHIP_CYCLES, MMD_FLT_NONE, -1);
        access(mk(24'h00F1FF, 1'b0, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXTENDED_SPECIAL_FUNCTION_AREA, ONCHIP_CYCLES, MMD_FLT_NONE, -1);
    endtask

    task automatic t_bits();
        access(mk(24'h00FD10, 1'b0, 1'b1, MMD_USE_DATA, 4'h0),
               MMD_TGT_INTERNAL_DUAL_PORT_RAM, 1, MMD_FLT_NONE, -1);
        access(mk(24'h00F600, 1'b0, 1'b1, MMD_USE_DATA, 4'h0),
               MMD_TGT_INTERNAL_DUAL_PORT_RAM, 0, MMD_FLT_BIT, -1);
    endtask

    task automatic t_gpr();
        cp <= 24'h00FC00;
        access(mk(24'h000000, 1'b1, 1'b0, MMD_USE_GPR, 4'h3),
               MMD_TGT_INTERNAL_DUAL_PORT_RAM, 1, MMD_FLT_NONE, -1);
        check("gpr word addr", route_out.addr, 24'h00FC06);
        access(mk(24'h000000, 1'b0, 1'b0, MMD_USE_GPR, 4'h3),
               MMD_TGT_INTERNAL_DUAL_PORT_RAM, 1, MMD_FLT_NONE, -1);
        check("gpr byte addr", route_out.addr, 24'h00FC03);
        cp <= 24'h00E000;
        access(mk(24'h000000, 1'b1, 1'b0, MMD_USE_GPR, 4'h2),
               MMD_TGT_EXT, 0, MMD_FLT_PLACE, -1);
        cp <= 24'h00FC00;
    endtask

    task automatic t_extension_ram();
        sys_cfg <= 16'h0004;
        extension_ram_en <= 1'b1;
        access(mk(24'h00E000, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXTENSION_RAM, EXTENSION_RAM_CYCLES, MMD_FLT_NONE, -1);
        access(mk(24'h00E7FF, 1'b0, 1'b0, MMD_USE_CODE, 4'h0),
               MMD_TGT_EXTENSION_RAM, EXTENSION_RAM_CYCLES, MMD_FLT_NONE, -1);
        access(mk(24'h00E010, 1'b0, 1'b1, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXTENSION_RAM, 0, MMD_FLT_BIT, -1);
        access(mk(24'h00E010, 1'b1, 1'b0, MMD_USE_STACK, 4'h0),
               MMD_TGT_EXTENSION_RAM, 0, MMD_FLT_PLACE, -1);
        extension_ram_en <= 1'b0;
        ext_delay <= 4'h5;
        access(mk(24'h00E400, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 7, MMD_FLT_NONE, -1);
    endtask

    task automatic t_can();
        sys_cfg <= 16'h0004;
        ext_delay <= 4'h0;
        access(mk(24'h00EF00, 1'b0, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_CAN, CAN_CYCLES, MMD_FLT_NONE, -1);
        access(mk(24'h512345, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 2, MMD_FLT_NONE, -1);
        check("seg lines", route_out.addr, 24'h012345);
        sys_cfg <= 16'hFFFB;
        access(mk(24'h00EFFF, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 2, MMD_FLT_NONE, -1);
    endtask

    task automatic t_windows();
        sys_cfg <= 16'h0000;
        windows[0] <= '{enable: 1'b1, base: 12'h100, mask: 12'hF00};
        windows[1] <= '{enable: 1'b1, base: 12'h100, mask: 12'hFF0};
        windows[2] <= '{enable: 1'b1, base: 12'h200, mask: 12'hF00};
        windows[3] <= '{enable: 1'b1, base: 12'h200, mask: 12'hFFF};
        access(mk(24'h100234, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 2, MMD_FLT_NONE, 2);
        access(mk(24'h180000, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 2, MMD_FLT_NONE, 1);
        access(mk(24'h200010, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 2, MMD_FLT_NONE, 4);
        access(mk(24'h280000, 1'b0, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 2, MMD_FLT_NONE, 3);
        access(mk(24'hFFFFFE, 1'b1, 1'b0, MMD_USE_DATA, 4'h0),
               MMD_TGT_EXT, 2, MMD_FLT_NONE, 0);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_in);
        #1;
        t_reset();
        @(posedge sys_clk_in);
        reset_in <= 1'b0;
        t_onchip();
        t_bits();
        t_gpr();
        t_extension_ram();
        t_can();
        t_windows();
        report_and_stop();
    end
endmodule
`default_nettype wire
